// [dv/bcw_core_props.sv]
// Port assertions for the clock, alarm and watchdog core.
`timescale 1ns/1ps
module bcw_core_props #(
  parameter int unsigned ADDR_W = 15
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_ok,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic irq_out_a_o,
  input wire logic irq_out_a_oe,
  input wire logic irq_out_b_o,
  input wire logic irq_out_b_oe,
  input wire logic square_wave_out_o,
  input wire logic square_wave_out_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  logic rd;
  assign rd = !ce_n && !oe_n && we_n && power_ok;
  // Control bits only move once a write has committed.
  sequence s_wr_end;
    !$past(we_n, 2) || !$past(we_n, 3);
  endsequence
  sequence s_hi_rd;
    rd && addr >= 14 ##1 rd && $stable(addr);
  endsequence
  property p_rd_answer; $rose(rd) |=> data_oe; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read got no data");
  property p_rd_drop; $fell(rd) |=> !data_oe; endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("data bus held after read");
  property p_hi_zero; s_hi_rd |-> data_o == 8'h00; endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("unmapped byte not zero");
  property p_wp_quiet; !power_ok [*2] |-> !data_oe; endproperty
  a_wp_quiet: assert property (p_wp_quiet)
    else $error("read served while protected");
  property p_sqw_oe; $changed(square_wave_out_oe) |-> s_wr_end; endproperty
  a_sqw_oe: assert property (p_sqw_oe)
    else $error("square wave enable moved alone");
  property p_b_pol; $changed(irq_out_b_o) |-> s_wr_end; endproperty
  a_b_pol: assert property (p_b_pol)
    else $error("output B drive moved alone");
  property p_b_src;
    irq_out_b_oe && irq_out_b_o |-> $past(power_ok);
  endproperty
  a_b_src: assert property (p_b_src)
    else $error("output B sourced without supply");
  property p_a_sink; irq_out_a_oe |-> !irq_out_a_o; endproperty
  a_a_sink: assert property (p_a_sink)
    else $error("output A driven high");
endmodule : bcw_core_props

bind bcw_core bcw_core_props #(.ADDR_W(ADDR_W)) u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .power_ok(power_ok), .addr(addr),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .data_i(data_i),
  .data_o(data_o), .data_oe(data_oe), .irq_out_a_o(irq_out_a_o),
  .irq_out_a_oe(irq_out_a_oe), .irq_out_b_o(irq_out_b_o),
  .irq_out_b_oe(irq_out_b_oe), .square_wave_out_o(square_wave_out_o),
  .square_wave_out_oe(square_wave_out_oe));

// [dv/bcw_host.sv]
// Host processor model for the bytewide register bus.
`timescale 1ns/1ps
module bcw_host #(
  parameter int unsigned ADDR_W = 15
) (
  input wire logic ref_clk,
  input wire logic data_oe,
  input wire logic [7:0] data_o,
  output logic [ADDR_W-1:0] addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] data_i
);
  // Extra write hold cycles, to play a slow processor.
  int slow = 0;
  initial begin
    addr = '0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    data_i = 8'h00;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    data_i = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (2 + slow) @(negedge ref_clk);
    ce_n = 1'b1;
    we_n = 1'b1;
    // A released line must not keep showing the written value.
    data_i = ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    int n = 0;
    @(negedge ref_clk);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    @(posedge ref_clk);
    while (data_oe !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      n++;
    end
    d = data_o;
    @(negedge ref_clk);
    ce_n = 1'b1;
    oe_n = 1'b1;
  endtask : rd
endmodule : bcw_host

// [dv/tb_bcd_clock_alarm_watchdog.sv]
// Self-checking bench for the clock, alarm and watchdog core.
`timescale 1ns/1ps
module tb_bcd_clock_alarm_watchdog;
  localparam int unsigned PW = 10;
  localparam int unsigned TK = 20;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_ok = 1'b1;
  logic [14:0] addr;
  logic ce_n, oe_n, we_n, data_oe, ia, ia_oe, ib, ib_oe, sq, sq_oe, s0;
  logic [7:0] data_i, data_o, rv;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'h0F225F16;
  int n, hi;
  logic [7:0] mdl [16];
  int ta [5] = '{0, 1, 2, 4, 6};
  logic [7:0] tv [5] = '{8'h90, 8'h59, 8'h10, 8'h05, 8'h03};
  // Minute, hour and day alarm bytes, then whether the alarm fires.
  logic [31:0] alm [6] = '{32'h80808001, 32'h11808001, 32'h11058001,
                          32'h11050301, 32'h11050400, 32'h12808000};
  always #25 ref_clk = ~ref_clk;
  bcw_core #(.TICK_CYCLES(TK), .SQW_HALF_CYCLES(4), .IRQ_PULSE_CYCLES(PW))
    dut (.ref_clk(ref_clk), .arst_n(arst_n), .power_ok(power_ok),
    .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .irq_out_a_o(ia),
    .irq_out_a_oe(ia_oe), .irq_out_b_o(ib), .irq_out_b_oe(ib_oe),
    .square_wave_out_o(sq), .square_wave_out_oe(sq_oe));
  bcw_host host (.ref_clk(ref_clk), .data_oe(data_oe), .data_o(data_o),
    .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .data_i(data_i));
  function automatic logic [7:0] msk(input int a);
    case (a)
      1, 2, 4: msk = 8'h7F;
      6: msk = 8'h07;
      7: msk = 8'h87;
      8: msk = 8'h3F;
      9: msk = 8'hDF;
      11: msk = 8'hFC;
      14, 15: msk = 8'h00;
      default: msk = 8'hFF;
    endcase
  endfunction : msk
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkp(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t pin %b exp %b", $time, got, exp);
    end
  endtask : chkp
  task automatic w(input int a, input logic [7:0] d);
    host.wr(15'(a), d);
    if (a < 16)
      mdl[a] = d & msk(a);
  endtask : w
  task automatic r(input int a);
    host.rd(15'(a), rv);
    chk(rv, a < 16 ? mdl[a] : 8'h00);
  endtask : r
  // Counts edges while the chosen interrupt pin's output enable stays at level lv.
  task automatic span(input bit b, input logic lv, output int k);
    k = 0;
    while ((b ? ib_oe : ia_oe) === lv && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : span
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #(20000 * 50);
    miscompares++;
    close_out();
  end
  initial begin
    for (int a = 0; a < 16; a++)
      mdl[a] = 8'h00;
    mdl[6] = 8'h01;
    mdl[8] = 8'h01;
    mdl[9] = 8'hC1;
    mdl[11] = 8'h8C;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    for (int a = 0; a < 16; a++)
      r(a);
    // random alarm bytes keep every mask clear, a legal setting.
    for (int a = 0; a < 16; a++)
      w(a, 8'($random(seed)) & (a inside {3, 5, 7} ? 8'h7F : 8'hFF) |
        (a == 9 ? 8'h80 : 8'h00));
    for (int a = 0; a < 16; a++)
      r(a);
    r('h7FFF);
    chkp(sq_oe, ~mdl[9][6]);
    chkp(ib, mdl[11][5]);
    power_ok = 1'b0;
    host.wr(15'h1, 8'h33);
    @(negedge ref_clk);
    power_ok = 1'b1;
    r(1);
    w(13, 8'h00);
    // Seconds start at zero so no stray minute alarm lands mid-test.
    w(1, 8'h00);
    w(9, 8'h00);
    w(11, 8'hF4);
    w(12, 8'h05);
    chkp(sq_oe, 1'b1);
    s0 = sq;
    repeat (4) @(negedge ref_clk);
    chkp(sq, ~s0);
    span(1, 1'b0, n);
    span(1, 1'b1, hi);
    chkp(hi inside {[PW:PW + 2]}, 1'b1);
    span(1, 1'b0, n);
    chkp(hi + n == 5 * TK, 1'b1);
    host.rd(15'hB, rv);
    chk(rv, 8'hF6);
    repeat (30) @(negedge ref_clk);
    r(11);
    host.slow = 2;
    w(11, 8'h84);
    host.slow = 0;
    span(0, 1'b0, n);
    chkp(ia_oe, 1'b1);
    chkp(ib_oe, 1'b0);
    repeat (40) @(negedge ref_clk);
    chkp(ia_oe, 1'b1);
    r(12);
    chkp(ia_oe, 1'b0);
    w(11, 8'h8C);
    repeat (150) @(negedge ref_clk);
    chkp(ia_oe | ib_oe, 1'b0);
    host.rd(15'hB, rv);
    chk(rv, 8'h8E);
    w(12, 8'h00);
    r(12);
    w(11, 8'h84);
    repeat (150) @(negedge ref_clk);
    chkp(ia_oe, 1'b0);
    // only the four legal mask combinations
    for (int i = 0; i < 6; i++) begin
      w(11, 8'h48);
      for (int k = 0; k < 5; k++)
        w(ta[k], tv[k]);
      for (int k = 0; k < 3; k++)
        w(3 + 2 * k, alm[i][31 - 8 * k -: 8]);
      w(11, 8'hC8);
      span(0, 1'b0, n);
      chkp(ia_oe, alm[i][0]);
      host.rd(15'hB, rv);
      chk(rv, {7'h64, alm[i][0]});
      host.rd(15'h2, rv);
      chk(rv, 8'h11);
      r(3);
      chkp(ia_oe, 1'b0);
    end
    w(11, 8'h48);
    w(4, 8'h51);
    w(2, 8'h59);
    w(1, 8'h59);
    w(0, 8'h90);
    w(11, 8'hC8);
    repeat (300) @(negedge ref_clk);
    host.rd(15'h4, rv);
    chk(rv, 8'h72);
    w(11, 8'h48);
    w(0, 8'h42);
    repeat (60) @(negedge ref_clk);
    r(0);
    w(11, 8'hC8);
    repeat (60) @(negedge ref_clk);
    host.rd(15'h0, rv);
    chkp(rv inside {[8'h43:8'h46]}, 1'b1);
    w(9, 8'h80);
    host.rd(15'h0, rv);
    hi = rv;
    repeat (60) @(negedge ref_clk);
    host.rd(15'h0, rv);
    chk(rv, 8'(hi));
    close_out();
  end
endmodule : tb_bcd_clock_alarm_watchdog

// [hw/bcw_core.sv]
// Bytewide clock, calendar, alarm and watchdog core with its register file.
`timescale 1ns/1ps
module bcw_core #(
  parameter int unsigned ADDR_W = 15,
  parameter int unsigned TICK_CYCLES = bcw_pkg::TICK_CYCLES,
  parameter int unsigned SQW_HALF_CYCLES = bcw_pkg::SQW_HALF_CYCLES,
  parameter int unsigned IRQ_PULSE_CYCLES = bcw_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_ok,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  output logic irq_out_a_o,
  output logic irq_out_a_oe,
  output logic irq_out_b_o,
  output logic irq_out_b_oe,
  output logic square_wave_out_o,
  output logic square_wave_out_oe
);
  import bcw_pkg::*;

  localparam int unsigned PW = $clog2(IRQ_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(IRQ_PULSE_CYCLES - 1);

  logic [7:0] regs [REG_COUNT];
  logic [7:0] t_hund, t_sec, t_min, t_hour, t_day, t_date, t_mon, t_year;
  logic [7:0] next_hund, next_sec, next_min, next_hour;
  logic [7:0] next_day, next_date, next_mon, next_year;
  logic roll, sec_wrap, day_carry, date_wrap;
  logic wr_act, rd_act, wr_act_q, rd_act_q, commit, rd_start;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data, rdata;
  logic wr_hit, rd_hit, wr_time, load_pend;
  logic te, tick, sq_phase, wd_fire, wd_reload;
  logic tod_event, alm_min_ok, alm_hour_ok, alm_day_ok;
  logic [1:0] irq_evt, irq_clr, irq_flag;
  logic act_tod, act_wd, a_act, b_act;

  assign te = regs[A_CMD][CMD_TE_BIT];

  bcw_tick #(
    .TICK_CYCLES(TICK_CYCLES),
    .SQW_HALF_CYCLES(SQW_HALF_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(~regs[A_MONTH][MON_OSC_DIS_BIT]),
    .tick(tick),
    .sq_phase(sq_phase)
  );

  bcw_wdog u_wdog (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick),
    .reload(wd_reload),
    .wd_lo(regs[A_WD_LO]),
    .wd_hi(regs[A_WD_HI]),
    .fire(wd_fire)
  );

  assign wr_act = ~ce_n & ~we_n & power_ok;
  assign rd_act = ~ce_n & ~oe_n & we_n & power_ok;
  assign commit = wr_act_q & ~wr_act & power_ok;
  assign rd_start = rd_act & ~rd_act_q;
  assign wr_hit = (wr_addr >> 4) == '0 && wr_addr[3:0] <= A_WD_HI;
  assign rd_hit = (addr >> 4) == '0 && addr[3:0] <= A_WD_HI;
  assign wr_time = wr_hit && wr_addr[3:0] <= A_YEAR &&
                   wr_addr[3:0] != A_ALM_MIN && wr_addr[3:0] != A_ALM_HOUR &&
                   wr_addr[3:0] != A_ALM_DAY;

  // The address and data are held through the strobe and used at its end.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_addr <= addr;
        wr_data <= data_i;
      end
    end
  end

  always_comb begin
    roll = (t_hund == HUND_MAX);
    next_hund = roll ? 8'h00 : bcd_inc(t_hund);
    sec_wrap = roll && (t_sec == SEC_MAX);
    next_sec = roll ? (sec_wrap ? 8'h00 : bcd_inc(t_sec)) : t_sec;
    next_min = t_min;
    next_hour = t_hour;
    next_day = t_day;
    next_date = t_date;
    next_mon = t_mon;
    next_year = t_year;
    day_carry = 1'b0;
    date_wrap = 1'b0;
    if (sec_wrap) begin
      next_min = (t_min == SEC_MAX) ? 8'h00 : bcd_inc(t_min);
      if (t_min == SEC_MAX) begin
        if (t_hour[HOUR_12H_BIT]) begin
          day_carry = t_hour[HOUR_PM_BIT] && ({3'b000, t_hour[4:0]}
                      == HOUR12_LAST);
          if ({3'b000, t_hour[4:0]} == HOUR12_MAX) begin
            next_hour = {t_hour[7:5], 5'h01};
          end else if ({3'b000, t_hour[4:0]} == HOUR12_LAST) begin
            next_hour = {t_hour[7:6], ~t_hour[HOUR_PM_BIT], HOUR12_MAX[4:0]};
          end else begin
            next_hour = {t_hour[7:5], 5'(bcd_inc({3'b000, t_hour[4:0]}))};
          end
        end else begin
          day_carry = (t_hour[5:0] == HOUR24_MAX[5:0]);
          next_hour = {t_hour[7:6], 6'(bcd_inc({2'b00, t_hour[5:0]}))};
          if (day_carry) begin
            next_hour = {t_hour[7:6], 6'h00};
          end
        end
      end
      if (day_carry) begin
        next_day = (t_day == DAY_MAX) ? 8'h01 : bcd_inc(t_day);
        date_wrap = (t_date == month_last(t_mon, t_year));
        next_date = date_wrap ? 8'h01 : bcd_inc(t_date);
        if (date_wrap) begin
          next_mon = (t_mon == MONTH_MAX) ? 8'h01 : bcd_inc(t_mon);
          if (t_mon == MONTH_MAX) begin
            next_year = (t_year == YEAR_MAX) ? 8'h00 : bcd_inc(t_year);
          end
        end
      end
    end
  end

  assign alm_min_ok = regs[A_ALM_MIN][ALM_MASK_BIT] ||
                      next_min[6:0] == regs[A_ALM_MIN][6:0];
  assign alm_hour_ok = regs[A_ALM_HOUR][ALM_MASK_BIT] ||
                       next_hour[6:0] == regs[A_ALM_HOUR][6:0];
  assign alm_day_ok = regs[A_ALM_DAY][ALM_MASK_BIT] ||
                      next_day[2:0] == regs[A_ALM_DAY][2:0];
  assign tod_event = tick && sec_wrap && alm_min_ok && alm_hour_ok &&
                     alm_day_ok;

  // A host time write waits here until transfers are enabled again.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_pend <= 1'b0;
    end else if (commit && wr_time) begin
      load_pend <= 1'b1;
    end else if (te && !wr_act_q) begin
      load_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      t_hund <= 8'h00;
      t_sec <= 8'h00;
      t_min <= 8'h00;
      t_hour <= 8'h00;
      t_day <= RST_DAY;
      t_date <= RST_DATE;
      t_mon <= {3'b000, RST_MONTH[4:0]};
      t_year <= 8'h00;
    end else if (load_pend && te && !wr_act_q) begin
      t_hund <= regs[A_HUND];
      t_sec <= regs[A_SEC];
      t_min <= regs[A_MIN];
      t_hour <= regs[A_HOUR];
      t_day <= regs[A_DAY];
      t_date <= regs[A_DATE];
      t_mon <= {3'b000, regs[A_MONTH][4:0]};
      t_year <= regs[A_YEAR];
    end else if (tick) begin
      t_hund <= next_hund;
      t_sec <= next_sec;
      t_min <= next_min;
      t_hour <= next_hour;
      t_day <= next_day;
      t_date <= next_date;
      t_mon <= next_mon;
      t_year <= next_year;
    end
  end

  // Register file; a host write in a tick cycle skips that copy-out.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
      regs[A_DAY] <= RST_DAY;
      regs[A_DATE] <= RST_DATE;
      regs[A_MONTH] <= RST_MONTH;
      regs[A_CMD] <= RST_CMD;
    end else if (commit) begin
      if (wr_hit) begin
        regs[wr_addr[3:0]] <= wr_data & reg_mask(wr_addr[3:0]);
      end
    end else if (tick && te && !load_pend) begin
      regs[A_HUND] <= next_hund;
      regs[A_SEC] <= next_sec;
      regs[A_MIN] <= next_min;
      regs[A_HOUR] <= next_hour;
      regs[A_DAY] <= next_day;
      regs[A_DATE] <= next_date;
      regs[A_MONTH] <= {regs[A_MONTH][7:5], next_mon[4:0]};
      regs[A_YEAR] <= next_year;
    end
  end

  assign irq_clr[CH_TOD] = (commit && wr_hit && (wr_addr[3:0] == A_ALM_MIN ||
    wr_addr[3:0] == A_ALM_HOUR || wr_addr[3:0] == A_ALM_DAY)) ||
    (rd_start && rd_hit && (addr[3:0] == A_ALM_MIN ||
    addr[3:0] == A_ALM_HOUR || addr[3:0] == A_ALM_DAY));
  assign irq_clr[CH_WD] = (commit && wr_hit && (wr_addr[3:0] == A_WD_LO ||
    wr_addr[3:0] == A_WD_HI)) || (rd_start && rd_hit &&
    (addr[3:0] == A_WD_LO || addr[3:0] == A_WD_HI));
  assign irq_evt[CH_TOD] = tod_event;
  assign irq_evt[CH_WD] = wd_fire;

  // Reload one cycle later so a fresh write value is already stored.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_reload <= 1'b0;
    end else begin
      wd_reload <= irq_clr[CH_WD];
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_irq
    logic flag;
    logic [PW-1:0] pcnt;
    assign irq_flag[ch] = flag;
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        flag <= 1'b0;
        pcnt <= '0;
      end else if (irq_evt[ch]) begin
        flag <= 1'b1;
        pcnt <= PULSE_LAST;
      end else if (irq_clr[ch]) begin
        flag <= 1'b0;
        pcnt <= '0;
      end else if (regs[A_CMD][CMD_PULSE_BIT] && flag) begin
        if (pcnt == '0) begin
          flag <= 1'b0;
        end else begin
          pcnt <= pcnt - 1'b1;
        end
      end
    end
  end

  assign act_tod = irq_flag[CH_TOD] & ~regs[A_CMD][CMD_TOD_MASK_BIT];
  assign act_wd = irq_flag[CH_WD] & ~regs[A_CMD][CMD_WD_MASK_BIT];
  assign a_act = regs[A_CMD][CMD_ROUTE_BIT] ? act_tod : act_wd;
  assign b_act = regs[A_CMD][CMD_ROUTE_BIT] ? act_wd : act_tod;

  always_comb begin
    rdata = 8'h00;
    if (rd_hit) begin
      rdata = regs[addr[3:0]];
      if (addr[3:0] == A_CMD) begin
        rdata = {regs[A_CMD][7:2], irq_flag[CH_WD], irq_flag[CH_TOD]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_o <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_o <= rd_act ? rdata : 8'h00;
      data_oe <= rd_act;
    end
  end

  // Output A only ever pulls low; output B can source only with supply up.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out_a_o <= 1'b0;
      irq_out_a_oe <= 1'b0;
      irq_out_b_o <= 1'b0;
      irq_out_b_oe <= 1'b0;
    end else begin
      irq_out_a_o <= 1'b0;
      irq_out_a_oe <= a_act;
      irq_out_b_o <= regs[A_CMD][CMD_POL_BIT];
      irq_out_b_oe <= b_act & (~regs[A_CMD][CMD_POL_BIT] | power_ok);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      square_wave_out_o <= 1'b0;
      square_wave_out_oe <= 1'b0;
    end else begin
      square_wave_out_o <= sq_phase;
      square_wave_out_oe <= ~regs[A_MONTH][MON_SQW_DIS_BIT];
    end
  end

endmodule : bcw_core

// [hw/bcw_pkg.sv]
// Constants, register map and BCD helpers for the clock, alarm and watchdog.
package bcw_pkg;

  localparam logic [3:0] A_HUND = 4'h0;
  localparam logic [3:0] A_SEC = 4'h1;
  localparam logic [3:0] A_MIN = 4'h2;
  localparam logic [3:0] A_ALM_MIN = 4'h3;
  localparam logic [3:0] A_HOUR = 4'h4;
  localparam logic [3:0] A_ALM_HOUR = 4'h5;
  localparam logic [3:0] A_DAY = 4'h6;
  localparam logic [3:0] A_ALM_DAY = 4'h7;
  localparam logic [3:0] A_DATE = 4'h8;
  localparam logic [3:0] A_MONTH = 4'h9;
  localparam logic [3:0] A_YEAR = 4'hA;
  localparam logic [3:0] A_CMD = 4'hB;
  localparam logic [3:0] A_WD_LO = 4'hC;
  localparam logic [3:0] A_WD_HI = 4'hD;
  localparam int unsigned REG_COUNT = 14;

  localparam int unsigned MON_OSC_DIS_BIT = 7;
  localparam int unsigned MON_SQW_DIS_BIT = 6;
  localparam int unsigned HOUR_12H_BIT = 6;
  localparam int unsigned HOUR_PM_BIT = 5;
  localparam int unsigned ALM_MASK_BIT = 7;
  localparam int unsigned CMD_TE_BIT = 7;
  localparam int unsigned CMD_ROUTE_BIT = 6;
  localparam int unsigned CMD_POL_BIT = 5;
  localparam int unsigned CMD_PULSE_BIT = 4;
  localparam int unsigned CMD_WD_MASK_BIT = 3;
  localparam int unsigned CMD_TOD_MASK_BIT = 2;
  localparam int unsigned CH_TOD = 0;
  localparam int unsigned CH_WD = 1;

  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'hC1;
  localparam logic [7:0] RST_CMD = 8'h8C;

  localparam logic [7:0] HUND_MAX = 8'h99;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_MAX = 8'h12;
  localparam logic [7:0] HOUR12_LAST = 8'h11;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_TIME_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned SQW_FREQ_HZ = 1024;
  localparam int unsigned SQW_HALF_CYCLES = CLK_HZ / (2 * SQW_FREQ_HZ);
  localparam int unsigned IRQ_PULSE_MS = 3;
  localparam int unsigned IRQ_PULSE_CYCLES =
    (CLK_HZ * IRQ_PULSE_MS + 999) / 1000;

  // Storage mask per address; zero bits never hold a written one.
  function automatic logic [7:0] reg_mask(input logic [3:0] a);
    unique case (a)
      A_SEC, A_MIN, A_HOUR: reg_mask = 8'h7F;
      A_DAY: reg_mask = 8'h07;
      A_ALM_DAY: reg_mask = 8'h87;
      A_DATE: reg_mask = 8'h3F;
      A_MONTH: reg_mask = 8'hDF;
      A_CMD: reg_mask = 8'hFC;
      default: reg_mask = 8'hFF;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  function automatic logic [7:0] month_last(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon[4:0])
      5'h02: month_last = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction : month_last

  function automatic logic [13:0] bcd_to_bin(input logic [7:0] lo,
                                             input logic [7:0] hi);
    bcd_to_bin = 14'(hi[7:4]) * 14'd1000 + 14'(hi[3:0]) * 14'd100 +
                 14'(lo[7:4]) * 14'd10 + 14'(lo[3:0]);
  endfunction : bcd_to_bin

endpackage : bcw_pkg

// [hw/bcw_tick.sv]
// Hundredths tick and square-wave phase derived from the reference clock.
`timescale 1ns/1ps
module bcw_tick #(
  parameter int unsigned TICK_CYCLES = bcw_pkg::TICK_CYCLES,
  parameter int unsigned SQW_HALF_CYCLES = bcw_pkg::SQW_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run,
  output logic tick,
  output logic sq_phase
);
  import bcw_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam int unsigned SW = $clog2(SQW_HALF_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [SW-1:0] SQW_LAST = SW'(SQW_HALF_CYCLES - 1);

  logic [TW-1:0] tcnt;
  logic [SW-1:0] scnt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= run && (tcnt == TICK_LAST);
      if (run) begin
        tcnt <= (tcnt == TICK_LAST) ? '0 : tcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scnt <= '0;
      sq_phase <= 1'b0;
    end else if (run) begin
      if (scnt == SQW_LAST) begin
        scnt <= '0;
        sq_phase <= ~sq_phase;
      end else begin
        scnt <= scnt + 1'b1;
      end
    end
  end

endmodule : bcw_tick

// [hw/bcw_wdog.sv]
// Watchdog countdown in hundredths of a second with periodic fire pulse.
`timescale 1ns/1ps
module bcw_wdog (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic reload,
  input wire logic [7:0] wd_lo,
  input wire logic [7:0] wd_hi,
  output logic fire
);
  import bcw_pkg::*;

  logic [13:0] load_val;
  logic [13:0] cnt;

  assign load_val = bcd_to_bin(wd_lo, wd_hi);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (reload) begin
        cnt <= load_val;
      end else if (tick && load_val != 14'd0) begin
        if (cnt <= 14'd1) begin
          fire <= 1'b1;
          cnt <= load_val;
        end else begin
          cnt <= cnt - 14'd1;
        end
      end
    end
  end

endmodule : bcw_wdog
